// ===== rtu_pkg.sv
// shared constants, state type and check-value step for the rtu slave engine
package rtu_pkg;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] MAX_UNIT_ADDR = 8'hF7;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h06;
    localparam logic [7:0] ERR_FLAG = 8'h80;
    localparam logic [7:0] EXC_BAD_CMD = 8'h01;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] EXC_ACCESS_FAIL = 8'h04;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] MIN_LEN = 4'h4;
    localparam logic [3:0] LEN_MAX = 4'hF;
    localparam logic [3:0] MAX_READ_WORDS = 4'hC;
    localparam logic [4:0] ERR_RLEN = 5'h05;
    localparam logic [4:0] WR_RLEN = 5'h08;
    localparam logic [4:0] RD_OVERHEAD = 5'h05;
    localparam logic [4:0] DATA_START = 5'h03;
    localparam int WORD_SLOTS = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 20;
    // one 11-bit character at 9600 baud
    localparam int CHAR_TIME_NS = 1145834;
    localparam int CHAR_CYCLES = (CHAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYCLES = (CHAR_CYCLES * 7 + 1) / 2;

    typedef enum logic [2:0] {
        ST_RX = 3'h0,
        ST_EVAL = 3'h1,
        ST_ACCESS = 3'h3,
        ST_SEND = 3'h2,
        ST_DRAIN = 3'h6
    } state_t;

    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

// ===== idle_gap_timer.sv
// line idle timer flagging a gap of at least the frame separation time
`timescale 1ns/1ns
module idle_gap_timer #(
    parameter int LIMIT = 200551
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic activity,
    output logic gap
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_W = CW'(LIMIT);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    assign cnt_nxt = activity ? '0 : ((cnt_r == LIMIT_W) ? cnt_r : cnt_r + 1'b1);
    assign gap = (cnt_r == LIMIT_W);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ===== byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic push;
    logic pop;

    assign out_valid = (wp_r != rp_r);
    assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    assign push = ce & in_valid & in_ready;
    assign pop = ce & out_valid & out_ready;
    assign out_data = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule

// ===== rtu_slave_frame_engine.sv
// rtu slave frame engine: framing, address filter, command decode, check value, replies
`timescale 1ns/1ns
// Operation
// - idle over 3.5 characters delimits frames
// - first byte is address, 0 broadcasts
// - answer only own unicast address
// - broadcast executed, never answered
// - one reply per own unicast request
// - command 0x03 reads consecutive words
// - command 0x06 writes one word
// - word-wide access only
// - read count 1 to 12
// - 16-bit fields sent high byte first
// - write frame has no count field
// - reply data holds read values
// - faulty or failed request gets error reply
// - every frame ends with two check bytes
// - check register starts all ones
// - xor byte, eight shifts, polynomial on carry
// - only data bits feed the check
// - check value low byte first
// - receiver recomputes and compares check value
// - drive line only while replying
module rtu_slave_frame_engine
    import rtu_pkg::*;
#(
    parameter int GAP_LIMIT = GAP_CYCLES,
    parameter int TX_FIFO_DEPTH = FIFO_DEPTH
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] UNIT_ADDR,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_ERR,
    input wire logic RX_BUSY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire logic TX_BUSY,
    output logic DRIVER_EN,
    output logic ACC_REQ,
    output logic ACC_WR,
    output logic ACC_BCAST,
    output logic [15:0] ACC_ADDR,
    output logic [15:0] ACC_WDATA,
    input wire logic ACC_ACK,
    input wire logic ACC_ERR,
    input wire logic [15:0] ACC_RDATA,
    output logic FRAME_DROP
);
    state_t state_r;
    logic [3:0] len_r;
    logic [7:0] frm_r [0:7];
    logic [15:0] rx_crc_r;
    logic rx_bad_r;
    logic is_err_r;
    logic [7:0] exc_r;
    logic [3:0] word_cnt_r;
    logic [3:0] idx_r;
    logic [15:0] rdata_r [0:WORD_SLOTS-1];
    logic [15:0] acc_addr_r;
    logic acc_req_r;
    logic [4:0] tx_idx_r;
    logic [15:0] tx_crc_r;
    logic drv_r;
    logic drop_r;

    // frame fields
    logic [7:0] f_addr;
    logic [7:0] f_cmd;
    logic [15:0] f_reg;
    logic [15:0] f_val;
    assign f_addr = frm_r[0];
    assign f_cmd = frm_r[1];
    assign f_reg = {frm_r[2], frm_r[3]};
    assign f_val = {frm_r[4], frm_r[5]};

    // idle gap detection
    logic gap;
    logic line_activity;
    assign line_activity = RX_BUSY | RX_VALID | TX_BUSY | drv_r;

    idle_gap_timer #(
        .LIMIT(GAP_LIMIT)
    ) u_gap (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .activity(line_activity),
        .gap(gap)
    );

    // receive side
    logic frame_end;
    logic new_frame;
    logic rx_take;
    logic [3:0] len_inc;
    assign frame_end = (state_r == ST_RX) && gap && (len_r != 4'h0);
    assign new_frame = gap || (len_r == 4'h0);
    assign rx_take = (state_r == ST_RX) && !frame_end && RX_VALID;
    assign len_inc = (len_r == LEN_MAX) ? len_r : len_r + 4'h1;

    // evaluation of a finished frame
    logic crc_ok;
    logic addr_bc;
    logic addr_me;
    logic own_valid;
    logic cmd_rd;
    logic cmd_wr;
    logic cnt_ok;
    logic [7:0] eval_exc;
    assign crc_ok = (rx_crc_r == CRC_RESIDUE) && (len_r >= MIN_LEN) && !rx_bad_r;
    assign own_valid = (UNIT_ADDR != BCAST_ADDR) && (UNIT_ADDR <= MAX_UNIT_ADDR);
    assign addr_bc = (f_addr == BCAST_ADDR);
    assign addr_me = own_valid && (f_addr == UNIT_ADDR);
    assign cmd_rd = (f_cmd == CMD_READ);
    assign cmd_wr = (f_cmd == CMD_WRITE);
    assign cnt_ok = (f_val[15:4] == 12'h000) && (f_val[3:0] != 4'h0)
        && (f_val[3:0] <= MAX_READ_WORDS);
    // only word commands are known; anything else is refused
    assign eval_exc = !(cmd_rd || cmd_wr) ? EXC_BAD_CMD :
        (len_r != REQ_LEN) ? EXC_BAD_VALUE :
        (cmd_rd && !cnt_ok) ? EXC_BAD_VALUE : 8'h00;

    // access sequencing
    logic acc_done;
    logic last_word;
    assign acc_done = acc_req_r && (ACC_ACK || ACC_ERR);
    assign last_word = (idx_r + 4'h1) == word_cnt_r;

    // reply byte generation
    logic [4:0] rlen;
    logic [4:0] dk;
    logic [15:0] rd_word;
    logic [7:0] body_byte;
    logic [7:0] tx_byte;
    logic is_crc_lo;
    logic is_crc_hi;
    logic fifo_ready;
    logic push;
    assign rlen = is_err_r ? ERR_RLEN : (cmd_rd ? RD_OVERHEAD + {word_cnt_r, 1'b0} : WR_RLEN);
    assign dk = tx_idx_r - DATA_START;
    assign rd_word = rdata_r[dk[4:1]];
    assign body_byte = (tx_idx_r == 5'h00) ? UNIT_ADDR :
        (tx_idx_r == 5'h01) ? (is_err_r ? (f_cmd | ERR_FLAG) : f_cmd) :
        (tx_idx_r == 5'h02) ? (is_err_r ? exc_r :
            (cmd_rd ? {3'h0, word_cnt_r, 1'b0} : f_reg[15:8])) :
        cmd_rd ? (dk[0] ? rd_word[7:0] : rd_word[15:8]) :
        (tx_idx_r == 5'h03) ? f_reg[7:0] :
        (tx_idx_r == 5'h04) ? f_val[15:8] : f_val[7:0];
    assign is_crc_lo = (tx_idx_r == rlen - 5'h02);
    assign is_crc_hi = (tx_idx_r == rlen - 5'h01);
    // check value appended low byte then high byte
    assign tx_byte = is_crc_lo ? tx_crc_r[7:0] :
        (is_crc_hi ? tx_crc_r[15:8] : body_byte);
    assign push = CE && (state_r == ST_SEND) && fifo_ready;

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_txq (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .in_valid(state_r == ST_SEND),
        .in_ready(fifo_ready),
        .in_data(tx_byte),
        .out_valid(TX_VALID),
        .out_ready(TX_READY),
        .out_data(TX_DATA)
    );

    logic tx_idle;
    assign tx_idle = !TX_VALID && !TX_BUSY;

    // state machine
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_r <= ST_RX;
            is_err_r <= 1'b0;
            exc_r <= 8'h00;
            word_cnt_r <= 4'h0;
            idx_r <= 4'h0;
            acc_addr_r <= 16'h0000;
            acc_req_r <= 1'b0;
            drop_r <= 1'b0;
        end else if (CE) begin
            drop_r <= 1'b0;
            unique case (state_r)
                ST_RX: begin
                    if (frame_end) begin
                        state_r <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    idx_r <= 4'h0;
                    acc_addr_r <= f_reg;
                    word_cnt_r <= cmd_rd ? f_val[3:0] : 4'h1;
                    exc_r <= eval_exc;
                    is_err_r <= (eval_exc != 8'h00);
                    if (!crc_ok || !(addr_bc || addr_me)) begin
                        state_r <= ST_RX;
                        drop_r <= 1'b1;
                    end else if (eval_exc != 8'h00) begin
                        state_r <= addr_bc ? ST_RX : ST_SEND;
                    end else begin
                        state_r <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    if (acc_done) begin
                        acc_req_r <= 1'b0;
                        idx_r <= idx_r + 4'h1;
                        acc_addr_r <= acc_addr_r + 16'h0001;
                        if (ACC_ERR) begin
                            is_err_r <= 1'b1;
                            exc_r <= EXC_ACCESS_FAIL;
                            state_r <= f_addr == BCAST_ADDR ? ST_RX : ST_SEND;
                        end else if (last_word) begin
                            state_r <= f_addr == BCAST_ADDR ? ST_RX : ST_SEND;
                        end
                    end else begin
                        acc_req_r <= 1'b1;
                    end
                end
                ST_SEND: begin
                    if (fifo_ready && is_crc_hi) begin
                        state_r <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (tx_idle) begin
                        state_r <= ST_RX;
                    end
                end
                default: begin
                    state_r <= ST_RX;
                end
            endcase
        end
    end

    // frame capture and running check value
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            len_r <= 4'h0;
            rx_crc_r <= CRC_INIT;
            rx_bad_r <= 1'b0;
        end else if (CE) begin
            if (state_r == ST_EVAL) begin
                len_r <= 4'h0;
            end else if (rx_take) begin
                if (new_frame) begin
                    len_r <= 4'h1;
                    rx_crc_r <= crc_byte(CRC_INIT, RX_DATA);
                    rx_bad_r <= RX_ERR;
                end else begin
                    len_r <= len_inc;
                    rx_crc_r <= crc_byte(rx_crc_r, RX_DATA);
                    rx_bad_r <= rx_bad_r | RX_ERR;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                frm_r[i] <= 8'h00;
            end
        end else if (CE && rx_take) begin
            if (new_frame) begin
                frm_r[0] <= RX_DATA;
            end else if (len_r < REQ_LEN) begin
                frm_r[len_r[2:0]] <= RX_DATA;
            end
        end
    end

    // read values gathered before the reply starts
    always_ff @(posedge CLK_SYS) begin
        if (CE && acc_done && ACC_ACK && cmd_rd) begin
            rdata_r[idx_r] <= ACC_RDATA;
        end
    end

    // reply emission and transmit check value
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tx_idx_r <= 5'h00;
            tx_crc_r <= CRC_INIT;
        end else if (CE) begin
            if (state_r != ST_SEND) begin
                tx_idx_r <= 5'h00;
                tx_crc_r <= CRC_INIT;
            end else if (push) begin
                tx_idx_r <= tx_idx_r + 5'h01;
                if (!is_crc_lo && !is_crc_hi) begin
                    tx_crc_r <= crc_byte(tx_crc_r, tx_byte);
                end
            end
        end
    end

    // line driver only while a reply is in flight
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            drv_r <= 1'b0;
        end else if (CE) begin
            // reply only follows a frame ended by a full idle gap
            drv_r <= (state_r == ST_SEND) || (state_r == ST_DRAIN);
        end
    end

    assign DRIVER_EN = drv_r;
    assign ACC_REQ = acc_req_r;
    assign ACC_WR = cmd_wr;
    assign ACC_BCAST = addr_bc;
    assign ACC_ADDR = acc_addr_r;
    assign ACC_WDATA = f_val;
    assign FRAME_DROP = drop_r;
endmodule

// ===== rtu_engine_monitor.sv
// port checker for the rtu slave frame engine
`timescale 1ns/1ns
module rtu_engine_monitor #(
    parameter int GAP_LIMIT = 20
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic RX_VALID,
    input wire logic RX_BUSY,
    input wire logic TX_VALID,
    input wire logic DRIVER_EN,
    input wire logic ACC_REQ,
    input wire logic ACC_WR,
    input wire logic ACC_BCAST,
    input wire logic [15:0] ACC_ADDR,
    input wire logic ACC_ACK,
    input wire logic ACC_ERR,
    input wire logic FRAME_DROP
);
    logic [31:0] idle_r;
    // cycles since the last receive activity
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST)
            idle_r <= '0;
        else if (RX_VALID || RX_BUSY)
            idle_r <= '0;
        else if (idle_r != 32'hFFFFFFFF)
            idle_r <= idle_r + 32'h1;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    AST_TX_IN_REPLY: assert property (TX_VALID |-> DRIVER_EN)
        else $error("reply byte offered with driver off");
    AST_REPLY_AFTER_GAP: assert property ($rose(DRIVER_EN) |-> idle_r >= 32'(GAP_LIMIT))
        else $error("driver enabled before idle gap");
    AST_REQ_HOLDS: assert property (ACC_REQ && !ACC_ACK && !ACC_ERR |=>
        ACC_REQ && $stable(ACC_ADDR) && $stable(ACC_WR))
        else $error("access request dropped or changed before answer");
    AST_REQ_RELEASE: assert property (ACC_REQ && (ACC_ACK || ACC_ERR) |=> !ACC_REQ)
        else $error("access request not released after answer");
    AST_NEXT_WORD: assert property (ACC_REQ && ACC_ACK && !ACC_WR ##1 !ACC_REQ ##1 ACC_REQ
        |-> ACC_ADDR == $past(ACC_ADDR, 2) + 16'h0001)
        else $error("read word address not consecutive");
    AST_WRITE_ONCE: assert property (ACC_REQ && ACC_WR && ACC_ACK |=> !ACC_REQ [*8])
        else $error("second access after a write");
    AST_ERR_ABORT: assert property (ACC_REQ && ACC_ERR |=> !ACC_REQ [*8])
        else $error("access continued after failure");
    AST_DROP_PULSE: assert property (FRAME_DROP |=> !FRAME_DROP)
        else $error("drop flag longer than one cycle");
    AST_DROP_SILENT: assert property (FRAME_DROP |-> !ACC_REQ && !DRIVER_EN ##1
        (!ACC_REQ && !DRIVER_EN) [*8])
        else $error("dropped frame caused access or reply");
    AST_BCAST_QUIET: assert property (ACC_REQ && ACC_BCAST |-> !DRIVER_EN && !TX_VALID)
        else $error("broadcast access while replying");
endmodule
bind rtu_slave_frame_engine rtu_engine_monitor #(.GAP_LIMIT(GAP_LIMIT)) i_mon (
    .CLK_SYS(CLK_SYS), .RST(RST), .RX_VALID(RX_VALID), .RX_BUSY(RX_BUSY),
    .TX_VALID(TX_VALID), .DRIVER_EN(DRIVER_EN), .ACC_REQ(ACC_REQ), .ACC_WR(ACC_WR),
    .ACC_BCAST(ACC_BCAST), .ACC_ADDR(ACC_ADDR), .ACC_ACK(ACC_ACK), .ACC_ERR(ACC_ERR),
    .FRAME_DROP(FRAME_DROP));

// ===== rtu_master_model.sv
// bus master model: byte sender with line activity, stalling reply sink
`timescale 1ns/1ns
module rtu_master_model (
    input wire logic clk,
    input wire logic drv_en,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_busy,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_busy
);
    logic [7:0] got[$];
    int busy_cnt = 0;
    int tick = 0;
    bit took = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hFF;
        rx_busy = 1'b0;
        tx_ready = 1'b0;
        tx_busy = 1'b0;
    end
    // frames only start after the line went idle
    task automatic send(input logic [7:0] q[$]);
        while (drv_en) @(negedge clk);
        foreach (q[i]) begin
            rx_busy = 1'b1;
            repeat (3) @(negedge clk);
            rx_busy = 1'b0;
            rx_valid = 1'b1;
            rx_data = q[i];
            @(negedge clk);
            rx_valid = 1'b0;
            rx_data = ~q[i];
        end
    endtask
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            took = 1'b1;
        end
    end
    // sink stalls every fifth cycle and while shifting
    always @(negedge clk) begin
        tick++;
        if (took)
            busy_cnt = 3;
        else if (busy_cnt > 0)
            busy_cnt--;
        took = 1'b0;
        tx_busy = busy_cnt > 0;
        tx_ready = busy_cnt == 0 && tick % 5 != 0;
    end
endmodule

// ===== rtu_slave_frame_engine_tb_top.sv
// self-checking testbench for the rtu slave frame engine
`timescale 1ns/1ns
module rtu_slave_frame_engine_tb_top;
    import rtu_pkg::*;
    typedef logic [7:0] bq_t[$];
    localparam int GAP = 20;
    logic CLK_SYS = 0, RST = 1, RX_VALID, RX_BUSY, TX_VALID, TX_READY, TX_BUSY, DRIVER_EN;
    logic ACC_REQ, ACC_WR, ACC_BCAST, ACC_ACK = 0, ACC_ERR = 0, FRAME_DROP;
    logic [7:0] UNIT_ADDR = 8'h01, RX_DATA, TX_DATA;
    logic [15:0] ACC_ADDR, ACC_WDATA, ACC_RDATA = 16'h0000, wd, wa;
    logic bc, ph = 0, acc_fail = 0, rx_err = 0;
    logic [31:0] seed = 32'h36FC;
    int errors = 0, cmp_count = 0, drops = 0;
    always #10 CLK_SYS = ~CLK_SYS;
    rtu_slave_frame_engine #(.GAP_LIMIT(GAP), .TX_FIFO_DEPTH(8)) i_dut (.CLK_SYS(CLK_SYS),
        .RST(RST), .CE(1'b1), .UNIT_ADDR(UNIT_ADDR), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
        .RX_ERR(rx_err), .RX_BUSY(RX_BUSY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
        .TX_READY(TX_READY), .TX_BUSY(TX_BUSY), .DRIVER_EN(DRIVER_EN), .ACC_REQ(ACC_REQ),
        .ACC_WR(ACC_WR), .ACC_BCAST(ACC_BCAST), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA),
        .ACC_ACK(ACC_ACK), .ACC_ERR(ACC_ERR), .ACC_RDATA(ACC_RDATA), .FRAME_DROP(FRAME_DROP));
    rtu_master_model i_mst (.clk(CLK_SYS), .drv_en(DRIVER_EN), .rx_valid(RX_VALID),
        .rx_data(RX_DATA), .rx_busy(RX_BUSY), .tx_valid(TX_VALID), .tx_data(TX_DATA),
        .tx_ready(TX_READY), .tx_busy(TX_BUSY));
    // parameter store answering with latency 0 or 1
    always @(negedge CLK_SYS) begin
        ph <= ~ph;
        ACC_ACK <= ACC_REQ && !acc_fail && ph;
        ACC_ERR <= ACC_REQ && acc_fail;
        ACC_RDATA <= ACC_ADDR ^ 16'h5A3C;
    end
    always @(posedge CLK_SYS) begin
        drops <= drops + int'(FRAME_DROP);
        if (ACC_REQ && ACC_ACK && ACC_WR) begin
            wd <= ACC_WDATA;
            wa <= ACC_ADDR;
            bc <= ACC_BCAST;
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic bq_t seal(bq_t q);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        return q;
    endfunction
    function automatic bq_t req(logic [7:0] ad, logic [7:0] cm, logic [15:0] pa, logic [15:0] v);
        return seal('{ad, cm, pa[15:8], pa[7:0], v[15:8], v[7:0]});
    endfunction
    function automatic bq_t rd_exp(logic [7:0] ad, logic [15:0] pa, int n);
        bq_t q;
        logic [15:0] w;
        q = '{ad, CMD_READ, 8'(2 * n)};
        for (int i = 0; i < n; i++) begin
            w = (pa + 16'(i)) ^ 16'h5A3C;
            q.push_back(w[15:8]);
            q.push_back(w[7:0]);
        end
        return seal(q);
    endfunction
    function automatic bq_t err_exp(logic [7:0] ad, logic [7:0] cm, logic [7:0] code);
        return seal('{ad, cm | 8'h80, code});
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input bq_t q, input bq_t exp, input logic drop);
        int n, d0;
        d0 = drops;
        i_mst.got.delete();
        i_mst.send(q);
        n = 0;
        while ((i_mst.got.size() < exp.size() || DRIVER_EN) && n < 4000) begin
            @(negedge CLK_SYS);
            n++;
        end
        repeat (GAP * 5) @(negedge CLK_SYS);
        chk16(16'(i_mst.got.size()), 16'(exp.size()));
        foreach (exp[i]) chk16({8'h00, i_mst.got[i]}, {8'h00, exp[i]});
        chk16(16'(drops - d0), {15'h0000, drop});
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #(20 * 80000);
        errors++;
        results();
    end
    initial begin
        logic [7:0] ua, cmds[4];
        logic [15:0] pa, pv;
        bq_t q;
        int n;
        cmds = '{8'h01, 8'h02, 8'h05, 8'h10};
        ua = 8'h01 + 8'(xs() % 247);
        repeat (20) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        RST = 0;
        UNIT_ADDR = ua;
        for (int k = 0; k < 6; k++) begin
            n = k == 0 ? 1 : k == 1 ? 12 : 1 + int'(xs() % 12);
            pa = 16'(xs());
            xfer(req(ua, CMD_READ, pa, 16'(n)), rd_exp(ua, pa, n), 0);
        end
        pa = 16'(xs());
        pv = 16'(xs());
        xfer(req(ua, CMD_WRITE, pa, pv), req(ua, CMD_WRITE, pa, pv), 0);
        chk16(wd, pv);
        chk16(wa, pa);
        xfer(req(ua, CMD_READ, pa, 16'd13), err_exp(ua, CMD_READ, 8'h03), 0);
        xfer(req(ua, CMD_READ, pa, 16'd0), err_exp(ua, CMD_READ, 8'h03), 0);
        foreach (cmds[i]) xfer(req(ua, cmds[i], pa, 16'd1), err_exp(ua, cmds[i], 8'h01), 0);
        acc_fail = 1;
        xfer(req(ua, CMD_READ, pa, 16'd3), err_exp(ua, CMD_READ, 8'h04), 0);
        acc_fail = 0;
        q = req(ua, CMD_READ, pa, 16'd2);
        q[7] ^= 8'h01;
        xfer(q, '{}, 1);
        rx_err = 1;
        xfer(req(ua, CMD_READ, pa, 16'd1), '{}, 1);
        rx_err = 0;
        xfer(req(ua == 8'hF7 ? 8'hF6 : ua + 8'h01, CMD_READ, pa, 16'd1), '{}, 1);
        xfer(req(8'h00, CMD_WRITE, pa + 16'h0001, ~pv), '{}, 0);
        chk16(wd, ~pv);
        chk16({15'h0000, bc}, 16'h0001);
        results();
    end
endmodule
